/* rtl/bmc_comparator.sv */
`timescale 1ns/100ps
`include "bmc_defs.svh"
module bmc_comparator
  import bmc_pkg::*;
#(
  parameter int ADDR_W = `BMC_ADDR_W
)
(
  input wire logic [ADDR_W-1:0] bp_addr_in,
  input wire logic [1:0] cond_type_in,
  input wire logic [1:0] size_in,
  input wire logic ext_sel_in,
  input wire logic [1:0] acc_kind_in,
  input wire logic acc_write_in,
  input wire logic [ADDR_W-1:0] acc_addr_in,
  input wire logic [2:0] acc_len_m1_in,
  output logic hit_out
);
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] bp_lo;
  logic [ADDR_W-1:0] bp_hi;
  logic [ADDR_W-1:0] acc_hi;
  logic kind_ok;
  always_comb
  begin
    // low bits masked by size force alignment
    unique case (size_in)
      `BMC_LEN_2: mask = {{(ADDR_W-1){1'b1}}, 1'b0};
      `BMC_LEN_4: mask = {{(ADDR_W-2){1'b1}}, 2'b00};
      default: mask = {ADDR_W{1'b1}};
    endcase
    bp_lo = bp_addr_in & mask;
    bp_hi = bp_lo | ~mask;
    acc_hi = acc_addr_in + ADDR_W'(acc_len_m1_in);
    unique case (cond_type_in)
      `BMC_RW_EXEC: kind_ok = (acc_kind_in == BMC_ACC_FETCH);
      `BMC_RW_WRITE: kind_ok = (acc_kind_in == BMC_ACC_MEM) && acc_write_in;
      `BMC_RW_IO: kind_ok = ext_sel_in && (acc_kind_in == BMC_ACC_IO);
      default: kind_ok = (acc_kind_in == BMC_ACC_MEM);
    endcase
    if (cond_type_in == `BMC_RW_EXEC)
      hit_out = kind_ok && (acc_addr_in == bp_lo);
    else
      hit_out = kind_ok && (acc_addr_in <= bp_hi) && (acc_hi >= bp_lo);
  end
endmodule : bmc_comparator

/* rtl/bmc_defs.svh */
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH
`define BMC_NUM_BP 4
`define BMC_EN_STRIDE 2
`define BMC_ADDR_W 32
`define BMC_IO_ADDR_W 16
`define BMC_CTRL_W 32
`define BMC_CTRL_RESET 32'h0000_0400
`define BMC_BIT_EXACT_LOCAL 8
`define BMC_BIT_EXACT_ALL 9
`define BMC_BIT_GUARD 13
`define BMC_FIELD_BASE 16
`define BMC_FIELD_STRIDE 4
`define BMC_SIZE_OFS 2
`define BMC_STAT_GUARD_BIT 13
`define BMC_STAT_W 16
`define BMC_RW_EXEC 2'h0
`define BMC_RW_WRITE 2'h1
`define BMC_RW_IO 2'h2
`define BMC_RW_DATA 2'h3
`define BMC_LEN_1 2'h0
`define BMC_LEN_2 2'h1
`define BMC_LEN_4 2'h3
`define BMC_DREG_SEL_W 3
`define BMC_DREG_STATUS 3'h6
`define BMC_DREG_CONTROL 3'h7
`endif

/* rtl/bmc_pkg.sv */
package bmc_pkg;
  `include "bmc_defs.svh"
  typedef enum logic [1:0]
  {
    BMC_ACC_NONE = 2'h0,
    BMC_ACC_FETCH = 2'h1,
    BMC_ACC_MEM = 2'h3,
    BMC_ACC_IO = 2'h2
  } bmc_acc_t;
endpackage : bmc_pkg

/* rtl/bmc_top.sv */
`timescale 1ns/100ps
`include "bmc_defs.svh"
// Contract
// - a met condition with its local enable set raises a debug exception.
// - all local enables clear on every task switch.
// - a met condition with its global enable set raises a debug exception.
// - global enables survive task switches.
// - exact-match bits 8 and 9 are stored only; software sets both.
// - guard bit set traps any debug-register move before it runs.
// - guarded access sets access-detected status before the exception.
// - entering the debug handler clears the guard bit.
// - extensions on: 00 exec, 01 write, 10 I/O, 11 data read/write.
// - extensions off: code 10 undefined, here never matches.
// - size codes 00 one, 01 two, 11 four bytes; 10 undefined.
// - size masks low breakpoint address bits for alignment.
// - I/O port address zero-extended from 16 to 32 bits.
// - data match when any accessed byte lies in the range.
// - execution match only on an instruction's first byte.
// - four 32-bit linear breakpoint addresses compared pre-translation.
// - on exception, all met-condition flags set, enabled or not.
module bmc_top
  import bmc_pkg::*;
#(
  parameter int NUM_BP = `BMC_NUM_BP,
  parameter int ADDR_W = `BMC_ADDR_W
)
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic DREG_WR_IN,
  input wire logic DREG_RD_IN,
  input wire logic [2:0] DREG_SEL_IN,
  input wire logic [31:0] DREG_WDATA_IN,
  input wire logic EXT_SEL_IN,
  input wire logic TASK_SWITCH_IN,
  input wire logic HANDLER_ENTRY_IN,
  input wire logic [1:0] ACC_KIND_IN,
  input wire logic ACC_WRITE_IN,
  input wire logic [31:0] ACC_ADDR_IN,
  input wire logic [2:0] ACC_LEN_M1_IN,
  output logic [31:0] DREG_RDATA_OUT,
  output logic DBG_EXC_OUT,
  output logic GUARD_FAULT_OUT
);
  logic [31:0] ctrl, next_ctrl;
  logic [ADDR_W-1:0] bp_addr [NUM_BP];
  logic [ADDR_W-1:0] next_bp_addr [NUM_BP];
  logic [`BMC_STAT_W-1:0] status, next_status;
  logic [31:0] next_rdata;
  logic next_exc, next_gfault;
  logic [NUM_BP-1:0] hit, armed;
  logic [NUM_BP-1:0] loc_en, glob_en;
  logic [ADDR_W-1:0] acc_addr;
  logic guard_trap;

  // port addresses carry no upper bits
  assign acc_addr = (ACC_KIND_IN == BMC_ACC_IO) ?
    {{(ADDR_W-`BMC_IO_ADDR_W){1'b0}}, ACC_ADDR_IN[`BMC_IO_ADDR_W-1:0]} :
    ACC_ADDR_IN[ADDR_W-1:0];

  // one comparator per breakpoint; all of them see the same access
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++)
    begin : g_bp
      bmc_comparator #(.ADDR_W(ADDR_W)) u_cmp
      (
        .bp_addr_in(bp_addr[gi]),
        .cond_type_in(ctrl[`BMC_FIELD_BASE+`BMC_FIELD_STRIDE*gi +: 2]),
        .size_in(ctrl[`BMC_FIELD_BASE+`BMC_FIELD_STRIDE*gi+`BMC_SIZE_OFS +: 2]),
        .ext_sel_in(EXT_SEL_IN),
        .acc_kind_in(ACC_KIND_IN),
        .acc_write_in(ACC_WRITE_IN),
        .acc_addr_in(acc_addr),
        .acc_len_m1_in(ACC_LEN_M1_IN),
        .hit_out(hit[gi])
      );
      // enables sit in pairs, the per-task one below the all-task one
      assign loc_en[gi] = ctrl[`BMC_EN_STRIDE*gi];
      assign glob_en[gi] = ctrl[`BMC_EN_STRIDE*gi+1];
      assign armed[gi] = hit[gi] && (loc_en[gi] || glob_en[gi]);
    end
  endgenerate

  // a move is judged in the cycle it is offered, before it can change anything
  assign guard_trap = ctrl[`BMC_BIT_GUARD] && (DREG_WR_IN || DREG_RD_IN);

  always_comb
  begin
    next_ctrl = ctrl;
    next_status = status;
    for (int i = 0; i < NUM_BP; i++)
      next_bp_addr[i] = bp_addr[i];
    next_exc = (|armed) || guard_trap;
    next_gfault = guard_trap;
    // read data holds between reads so the core may take it late
    next_rdata = DREG_RDATA_OUT;
    // a trapped move is never carried out
    if (DREG_WR_IN && !guard_trap)
    begin
      if (DREG_SEL_IN < 3'(NUM_BP))
        next_bp_addr[DREG_SEL_IN[1:0]] = DREG_WDATA_IN[ADDR_W-1:0];
      else if (DREG_SEL_IN == `BMC_DREG_STATUS)
        next_status = DREG_WDATA_IN[`BMC_STAT_W-1:0];
      else if (DREG_SEL_IN == `BMC_DREG_CONTROL)
        next_ctrl = DREG_WDATA_IN;
    end
    if (DREG_RD_IN && !guard_trap)
    begin
      if (DREG_SEL_IN < 3'(NUM_BP))
        next_rdata = bp_addr[DREG_SEL_IN[1:0]];
      else if (DREG_SEL_IN == `BMC_DREG_STATUS)
        next_rdata = {16'h0000, status};
      else if (DREG_SEL_IN == `BMC_DREG_CONTROL)
        next_rdata = ctrl;
      else
        next_rdata = 32'h0000_0000;
    end
    // hardware set wins over a same-cycle status write
    if (next_exc)
      next_status[NUM_BP-1:0] = status[NUM_BP-1:0] | hit;
    if (guard_trap)
      next_status[`BMC_STAT_GUARD_BIT] = 1'b1;
    // task switch and handler entry win over a same-cycle software write
    if (TASK_SWITCH_IN)
      for (int i = 0; i < NUM_BP; i++)
        next_ctrl[`BMC_EN_STRIDE*i] = 1'b0;
    if (HANDLER_ENTRY_IN)
      next_ctrl[`BMC_BIT_GUARD] = 1'b0;
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      // guard comes up clear, so the first move after reset is never trapped
      ctrl <= `BMC_CTRL_RESET;
      status <= '0;
      for (int i = 0; i < NUM_BP; i++)
        bp_addr[i] <= '0;
      DREG_RDATA_OUT <= 32'h0000_0000;
      DBG_EXC_OUT <= 1'b0;
      GUARD_FAULT_OUT <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      status <= next_status;
      for (int i = 0; i < NUM_BP; i++)
        bp_addr[i] <= next_bp_addr[i];
      DREG_RDATA_OUT <= next_rdata;
      DBG_EXC_OUT <= next_exc;
      GUARD_FAULT_OUT <= next_gfault;
    end
  end

  // checks watch the registered answers one edge after their cause; the I/O checks look in the same cycle
  AST_LOCAL_CLR: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    TASK_SWITCH_IN |=> loc_en == '0)
    else $error("local enables survived a task switch");
  AST_GLOBAL_KEEP: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    TASK_SWITCH_IN && !DREG_WR_IN |=> glob_en == $past(glob_en))
    else $error("global enables changed on task switch");

  AST_LOCAL_EXC: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (|(hit & loc_en)) |=> DBG_EXC_OUT)
    else $error("locally enabled hit gave no exception");
  AST_GLOBAL_EXC: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (|(hit & glob_en)) |=> DBG_EXC_OUT)
    else $error("globally enabled hit gave no exception");
  AST_EXC_ON_HIT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (|armed) |=> DBG_EXC_OUT)
    else $error("armed hit gave no exception");
  AST_NO_SPURIOUS: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !(|armed) && !guard_trap |=> !DBG_EXC_OUT)
    else $error("exception without cause");

  AST_EXACT_KEEP: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    DREG_WR_IN && !guard_trap && DREG_SEL_IN == `BMC_DREG_CONTROL |=>
    ctrl[`BMC_BIT_EXACT_ALL:`BMC_BIT_EXACT_LOCAL] ==
    $past(DREG_WDATA_IN[`BMC_BIT_EXACT_ALL:`BMC_BIT_EXACT_LOCAL]))
    else $error("exact-match bits not stored");

  // a guarded move is refused, reported and leaves read data and, barring a task switch or handler entry, ctrl as they were
  AST_GUARD: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    guard_trap |=> GUARD_FAULT_OUT && DBG_EXC_OUT && status[`BMC_STAT_GUARD_BIT])
    else $error("guard trap not reported");
  AST_GUARD_BLOCKS: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    guard_trap && !HANDLER_ENTRY_IN && !TASK_SWITCH_IN |=> ctrl == $past(ctrl))
    else $error("guarded write took effect");
  AST_GUARD_RDATA: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    guard_trap |=> $stable(DREG_RDATA_OUT))
    else $error("guarded read returned data");
  AST_GFAULT_CAUSE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !guard_trap |=> !GUARD_FAULT_OUT)
    else $error("guard fault without a guarded move");
  AST_HANDLER: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    HANDLER_ENTRY_IN |=> !ctrl[`BMC_BIT_GUARD])
    else $error("guard not cleared on handler entry");

  AST_FLAGS: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    next_exc && !DREG_WR_IN |=> (status[NUM_BP-1:0] & $past(hit)) == $past(hit))
    else $error("met-condition flags not set");
  AST_STATUS_QUIET: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !next_exc && !DREG_WR_IN |=> status == $past(status))
    else $error("status changed without an exception");

  AST_IO_EXT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    ACC_KIND_IN == BMC_ACC_IO |-> acc_addr[ADDR_W-1:`BMC_IO_ADDR_W] == '0)
    else $error("port address not zero-extended");
  AST_IO_LEGACY: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !EXT_SEL_IN && ACC_KIND_IN == BMC_ACC_IO |-> hit == '0)
    else $error("port access matched with extensions off");

  // main scenarios
  COV_HIT: cover property (@(posedge CORE_CLK_IN) |armed);
  COV_GUARD: cover property (@(posedge CORE_CLK_IN) guard_trap);
  COV_TASK: cover property (@(posedge CORE_CLK_IN) TASK_SWITCH_IN && ctrl[0]);
  COV_UNARMED: cover property (@(posedge CORE_CLK_IN) (|hit) && !(|armed));
  COV_IO: cover property (@(posedge CORE_CLK_IN) ACC_KIND_IN == BMC_ACC_IO && (|hit));
endmodule : bmc_top

/* tb/bmc_core_model.sv */
`timescale 1ns/100ps
module bmc_core_model
  import bmc_pkg::*;
(
  input wire logic clk_in,
  output logic [3:0] ctl_out,
  output logic [2:0] sel_out,
  output logic [31:0] wdata_out,
  output logic [1:0] kind_out,
  output logic write_out,
  output logic [31:0] addr_out,
  output logic [2:0] len_out
);
  // ctl_out bits: handler entry, task switch, register read, register write
  initial
  begin
    ctl_out = 4'h0;
    sel_out = 3'h0;
    wdata_out = 32'h0;
    kind_out = BMC_ACC_NONE;
    write_out = 1'b0;
    addr_out = 32'h0;
    len_out = 3'h0;
  end

  // one request per call, then an idle cycle; idle fields flip so nothing stale can match
  task automatic cyc(input logic [1:0] k, input logic w, input logic [31:0] a,
      input logic [2:0] l, input logic [3:0] c, input logic [2:0] s, input logic [31:0] d);
    @(negedge clk_in);
    kind_out = k;
    write_out = w;
    addr_out = a;
    len_out = l;
    ctl_out = c;
    sel_out = s;
    wdata_out = d;
    @(negedge clk_in);
    kind_out = BMC_ACC_NONE;
    ctl_out = 4'h0;
    write_out = ~w;
    addr_out = ~a;
    len_out = ~l;
    sel_out = ~s;
    wdata_out = ~d;
  endtask : cyc
endmodule : bmc_core_model

/* tb/bmc_top_test.sv */
`timescale 1ns/100ps
module bmc_top_test;
  import bmc_pkg::*;
  typedef struct {logic [1:0] k; logic w; logic [31:0] a; logic [2:0] l; logic e;} bmc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ext = 1'b1;
  logic [3:0] ctl;
  logic [2:0] sel, len;
  logic [1:0] kind;
  logic aw, exc, gf;
  logic [31:0] wd, aa, rdat;
  int err_total = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  bmc_row_t rows [10] = '{
    '{BMC_ACC_MEM, 1'b0, 32'h000A0001, 3'h0, 1'b1}, '{BMC_ACC_MEM, 1'b0, 32'h000A0000, 3'h1, 1'b1},
    '{BMC_ACC_MEM, 1'b1, 32'h000A0002, 3'h0, 1'b1}, '{BMC_ACC_MEM, 1'b0, 32'h000A0002, 3'h0, 1'b0},
    '{BMC_ACC_MEM, 1'b0, 32'h000A0003, 3'h3, 1'b0}, '{BMC_ACC_MEM, 1'b0, 32'h000B0003, 3'h0, 1'b1},
    '{BMC_ACC_MEM, 1'b0, 32'h000B0000, 3'h1, 1'b0}, '{BMC_ACC_MEM, 1'b1, 32'h000C0003, 3'h0, 1'b1},
    '{BMC_ACC_MEM, 1'b0, 32'h000C0000, 3'h3, 1'b0}, '{BMC_ACC_MEM, 1'b1, 32'h000C0002, 3'h1, 1'b1}};

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  bmc_core_model i_bmc_core_model (.clk_in(clk), .ctl_out(ctl), .sel_out(sel), .wdata_out(wd),
    .kind_out(kind), .write_out(aw), .addr_out(aa), .len_out(len));

  bmc_top i_bmc_top (.CORE_CLK_IN(clk), .RST_IN(rst), .DREG_WR_IN(ctl[0]), .DREG_RD_IN(ctl[1]),
    .DREG_SEL_IN(sel), .DREG_WDATA_IN(wd), .EXT_SEL_IN(ext), .TASK_SWITCH_IN(ctl[2]),
    .HANDLER_ENTRY_IN(ctl[3]), .ACC_KIND_IN(kind), .ACC_WRITE_IN(aw), .ACC_ADDR_IN(aa),
    .ACC_LEN_M1_IN(len), .DREG_RDATA_OUT(rdat), .DBG_EXC_OUT(exc), .GUARD_FAULT_OUT(gf));

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_exc(input logic [1:0] exp);
    cmp_reg({30'h0, gf, exc}, {30'h0, exp});
  endtask : cmp_exc

  task automatic wreg(input logic [2:0] s, input logic [31:0] d);
    i_bmc_core_model.cyc(BMC_ACC_NONE, 1'b0, 32'h0, 3'h0, 4'h1, s, d);
  endtask : wreg

  task automatic rreg(input logic [2:0] s);
    i_bmc_core_model.cyc(BMC_ACC_NONE, 1'b0, 32'h0, 3'h0, 4'h2, s, 32'h0);
  endtask : rreg

  task automatic pulse(input logic [3:0] c);
    i_bmc_core_model.cyc(BMC_ACC_NONE, 1'b0, 32'h0, 3'h0, c, 3'h0, 32'h0);
  endtask : pulse

  task automatic acc(input logic [1:0] k, input logic w, input logic [31:0] a,
      input logic [2:0] l, input logic e);
    i_bmc_core_model.cyc(k, w, a, l, 4'h0, 3'h0, 32'h0);
    cmp_exc({1'b0, e});
  endtask : acc

  task automatic results;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 2000)
    begin
      err_total++;
      results();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rreg(3'h7);
    cmp_reg(rdat, 32'h00000400);
    rreg(3'h6);
    cmp_reg(rdat, 32'h0);
    wreg(3'h0, 32'h000A0001);
    wreg(3'h1, 32'h000A0002);
    // unaligned on purpose: the size field must mask the low bits
    wreg(3'h2, 32'h000B0003);
    wreg(3'h3, 32'h000C0002);
    rreg(3'h2);
    cmp_reg(rdat, 32'h000B0003);
    wreg(3'h7, 32'hD71303AA);
    foreach (rows[i])
      acc(rows[i].k, rows[i].w, rows[i].a, rows[i].l, rows[i].e);
    wreg(3'h7, 32'h00030001);
    acc(BMC_ACC_MEM, 1'b0, 32'h000A0001, 3'h0, 1'b1);
    pulse(4'h4);
    acc(BMC_ACC_MEM, 1'b0, 32'h000A0001, 3'h0, 1'b0);
    wreg(3'h7, 32'h00030002);
    pulse(4'h4);
    acc(BMC_ACC_MEM, 1'b0, 32'h000A0001, 3'h0, 1'b1);
    rreg(3'h7);
    cmp_reg(rdat & 32'hFF, 32'h02);
    wreg(3'h6, 32'h0);
    wreg(3'h7, 32'h00130002);
    acc(BMC_ACC_MEM, 1'b1, 32'h000A0001, 3'h1, 1'b1);
    rreg(3'h6);
    cmp_reg(rdat & 32'hF, 32'h3);
    wreg(3'h1, 32'h00000060);
    wreg(3'h7, 32'h0020000A);
    acc(BMC_ACC_FETCH, 1'b0, 32'h000A0001, 3'h0, 1'b1);
    acc(BMC_ACC_FETCH, 1'b0, 32'h000A0000, 3'h1, 1'b0);
    acc(BMC_ACC_MEM, 1'b0, 32'h000A0001, 3'h0, 1'b0);
    acc(BMC_ACC_IO, 1'b1, 32'hFFFF0060, 3'h0, 1'b1);
    ext = 1'b0;
    acc(BMC_ACC_IO, 1'b1, 32'hFFFF0060, 3'h0, 1'b0);
    ext = 1'b1;
    wreg(3'h7, 32'h000B0002);
    acc(BMC_ACC_MEM, 1'b0, 32'h000A0000, 3'h0, 1'b0);
    acc(BMC_ACC_MEM, 1'b0, 32'h000A0001, 3'h0, 1'b1);
    wreg(3'h6, 32'h0);
    wreg(3'h7, 32'h00002000);
    rreg(3'h7);
    cmp_exc(2'h3);
    pulse(4'h8);
    rreg(3'h7);
    cmp_reg(rdat & 32'h2000, 32'h0);
    rreg(3'h6);
    cmp_reg(rdat & 32'h2000, 32'h2000);
    wreg(3'h7, 32'h00002000);
    rreg(3'h0);
    cmp_exc(2'h3);
    // reset lands while the trapped move's fault still stands
    rst = 1'b1;
    @(negedge clk);
    cmp_exc(2'h0);
    cmp_reg(rdat, 32'h0);
    @(negedge clk);
    rst = 1'b0;
    rreg(3'h7);
    cmp_exc(2'h0);
    cmp_reg(rdat, 32'h00000400);
    rreg(3'h6);
    cmp_reg(rdat, 32'h0);
    results();
  end
endmodule : bmc_top_test
